// file: rtl/sbst_handler.sv
// Command handler: status byte, self-tests, wait and routing parameter checks.
// Assumes decoded commands from a parser and test hardware on the same clock.
`default_nettype none

// Summary of operation
// - Status byte query replies the byte; bit six carries master summary.
// - Bit 4 message available, bit 5 event summary, bit 6 master; others zero.
// - Self-test query runs internal test, replies 0 pass or 1 fail.
// - After the self-test the device is put in its instrument reset state.
// - Wait command stalls all later commands until nothing is pending.
// - Diagnostics ignore config mode; card argument 1 to 4 or all.
// - Card clear erases the stored relay result of one or all cards.
// - Card execute tests selected cards; 1 if any fails, else 0.
// - Host fits the adapter; afterwards tested cards return to power-on setup.
// - Card state takes one card 1 to 4; replies 1, 0, or -1.
// - Frame clear erases the selected controller or panel test result.
// - Controller test ends in reset state; panel test leaves state alone.
// - Panel test waits for a key; none in ten seconds records fail.
// - Frame execute replies 1 or 0; frame state replies 1, 0, -1.
// - Open disconnects input from output; close joins them.
// - Routing parameters use the fixed rule, sequence, config, boolean codes.
// - Operation-complete is 1 with nothing pending, 0 while anything pends.
// - Master summary is the OR of status bits enabled by the request mask.
// - Event summary is the OR of enabled standard event status bits.
module sbst_handler #(
	parameter int unsigned PANEL_TIMEOUT_CYC = sbst_pkg::PANEL_TIMEOUT_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire logic [3:0] cmd_code,
	input wire logic [2:0] cmd_arg,
	input wire logic [1:0] cmd_value,
	output logic cmd_ready,
	output logic cmd_error,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	input wire logic [7:0] event_status,
	input wire logic [7:0] event_enable,
	input wire logic [7:0] request_enable,
	input wire logic out_queue_empty,
	input wire logic ops_pending,
	output logic [7:0] summary_status_byte,
	output logic op_complete,
	output logic hw_test_req,
	output logic [1:0] hw_test_kind,
	output logic [2:0] hw_test_card,
	input wire logic hw_test_done,
	input wire logic hw_test_fail,
	input wire logic panel_key,
	output logic inst_reset,
	output logic [3:0] card_poweron,
	output logic route_valid,
	output logic [2:0] route_op,
	output logic [2:0] route_card,
	output logic [1:0] route_value,
	output logic channel_config
);

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_WAIT_OPS = 4'b0010,
		ST_HW_TEST = 4'b0100,
		ST_PANEL = 4'b1000
	} sbst_state_t;

	typedef struct packed {
		sbst_state_t state;
		logic ready;
		logic error;
		logic rsp_valid;
		logic [7:0] rsp_data;
		logic [7:0] stb;
		logic opc;
		logic test_req;
		logic [1:0] test_kind;
		logic [2:0] test_card;
		logic [2:0] last_card;
		logic acc_fail;
		logic wr_en;
		logic [2:0] wr_idx;
		logic wr_fail;
		logic [sbst_pkg::RES_ENTRIES-1:0] clr_mask;
		logic panel_start;
		logic inst_reset;
		logic [3:0] card_poweron;
		logic route_valid;
		logic [2:0] route_op;
		logic [2:0] route_card;
		logic [1:0] route_value;
		logic cfg_normal;
	} sbst_main_t;

	sbst_main_t s_r;
	sbst_main_t s_nxt;
	logic [2:0] rd_idx;
	logic [1:0] rd_code;
	logic panel_done;
	logic panel_fail;
	logic [7:0] stb_now;
	logic mav;
	logic esb;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic card_in_range(input logic [2:0] arg);
		card_in_range = (arg >= sbst_pkg::CARD_FIRST) && (arg <= sbst_pkg::CARD_LAST);
	endfunction : card_in_range

	function automatic logic [sbst_pkg::RES_ENTRIES-1:0] card_clear(input logic [2:0] arg);
		logic [sbst_pkg::RES_ENTRIES-1:0] m;
		m = '0;
		if (arg == sbst_pkg::CARD_ALL) begin
			m[sbst_pkg::CARD_COUNT-1:0] = '1;
		end else begin
			m[3'(arg - 3'h1)] = 1'b1;
		end
		card_clear = m;
	endfunction : card_clear

	function automatic logic [7:0] code_reply(input logic [1:0] code);
		unique case (code)
			sbst_pkg::RES_PASS: code_reply = sbst_pkg::RSP_PASS;
			sbst_pkg::RES_FAIL: code_reply = sbst_pkg::RSP_FAIL;
			default: code_reply = sbst_pkg::RSP_NONE;
		endcase
	endfunction : code_reply

	// ----------------------------------------------------------------
	// Status byte
	// ----------------------------------------------------------------
	always_comb begin
		mav = !out_queue_empty;
		esb = |(event_status & event_enable);
		stb_now = sbst_pkg::STB_RESET;
		stb_now[sbst_pkg::STB_MAV_BIT] = mav;
		stb_now[sbst_pkg::STB_ESB_BIT] = esb;
		// Bit six of the enable mask is undefined, so it never feeds itself
		stb_now[sbst_pkg::STB_MSS_BIT] = |(stb_now & request_enable);
	end

	// Result read index: cards sit below the two frame entries
	always_comb begin
		if (cmd_code == sbst_pkg::CMD_FRAME_STATE) begin
			rd_idx = cmd_arg[0] ? sbst_pkg::RES_IDX_PANEL : sbst_pkg::RES_IDX_CTRL;
		end else begin
			rd_idx = 3'(cmd_arg - 3'h1);
		end
	end

	// ----------------------------------------------------------------
	// Command sequencer
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.error = 1'b0;
		s_nxt.rsp_valid = 1'b0;
		s_nxt.wr_en = 1'b0;
		s_nxt.clr_mask = '0;
		s_nxt.panel_start = 1'b0;
		s_nxt.inst_reset = 1'b0;
		s_nxt.card_poweron = '0;
		s_nxt.route_valid = 1'b0;
		s_nxt.stb = stb_now;
		s_nxt.opc = !ops_pending;
		unique case (s_r.state)
			ST_IDLE: begin
				if (cmd_valid) begin
					case (cmd_code)
						sbst_pkg::CMD_STB_QUERY: begin
							s_nxt.rsp_valid = 1'b1;
							s_nxt.rsp_data = stb_now;
						end
						sbst_pkg::CMD_SELFTEST_QUERY: begin
							s_nxt.test_req = 1'b1;
							s_nxt.test_kind = sbst_pkg::HW_INTERNAL;
							s_nxt.test_card = sbst_pkg::CARD_AUTO;
							s_nxt.state = ST_HW_TEST;
						end
						sbst_pkg::CMD_WAIT: begin
							if (ops_pending) begin
								s_nxt.state = ST_WAIT_OPS;
							end
						end
						sbst_pkg::CMD_CARD_CLEAR: begin
							// Diagnostics never look at the channel config mode
							if (card_in_range(cmd_arg) || cmd_arg == sbst_pkg::CARD_ALL) begin
								s_nxt.clr_mask = card_clear(cmd_arg);
							end else begin
								s_nxt.error = 1'b1;
							end
						end
						sbst_pkg::CMD_CARD_EXEC: begin
							if (card_in_range(cmd_arg) || cmd_arg == sbst_pkg::CARD_ALL) begin
								s_nxt.test_req = 1'b1;
								s_nxt.test_kind = sbst_pkg::HW_CARD;
								s_nxt.acc_fail = 1'b0;
								if (cmd_arg == sbst_pkg::CARD_ALL) begin
									s_nxt.test_card = sbst_pkg::CARD_FIRST;
									s_nxt.last_card = sbst_pkg::CARD_LAST;
								end else begin
									s_nxt.test_card = cmd_arg;
									s_nxt.last_card = cmd_arg;
								end
								s_nxt.state = ST_HW_TEST;
							end else begin
								s_nxt.error = 1'b1;
							end
						end
						sbst_pkg::CMD_CARD_STATE: begin
							if (card_in_range(cmd_arg)) begin
								s_nxt.rsp_valid = 1'b1;
								s_nxt.rsp_data = code_reply(rd_code);
							end else begin
								s_nxt.error = 1'b1;
							end
						end
						sbst_pkg::CMD_FRAME_CLEAR: begin
							if (cmd_arg == sbst_pkg::FRAME_CTRL) begin
								s_nxt.clr_mask[sbst_pkg::RES_IDX_CTRL] = 1'b1;
							end else if (cmd_arg == sbst_pkg::FRAME_PANEL) begin
								s_nxt.clr_mask[sbst_pkg::RES_IDX_PANEL] = 1'b1;
							end else begin
								s_nxt.error = 1'b1;
							end
						end
						sbst_pkg::CMD_FRAME_EXEC: begin
							if (cmd_arg == sbst_pkg::FRAME_CTRL) begin
								s_nxt.test_req = 1'b1;
								s_nxt.test_kind = sbst_pkg::HW_CONTROLLER;
								s_nxt.test_card = sbst_pkg::CARD_AUTO;
								s_nxt.state = ST_HW_TEST;
							end else if (cmd_arg == sbst_pkg::FRAME_PANEL) begin
								s_nxt.panel_start = 1'b1;
								s_nxt.state = ST_PANEL;
							end else begin
								s_nxt.error = 1'b1;
							end
						end
						sbst_pkg::CMD_FRAME_STATE: begin
							if (cmd_arg == sbst_pkg::FRAME_CTRL || cmd_arg == sbst_pkg::FRAME_PANEL) begin
								s_nxt.rsp_valid = 1'b1;
								s_nxt.rsp_data = code_reply(rd_code);
							end else begin
								s_nxt.error = 1'b1;
							end
						end
						sbst_pkg::CMD_ROUTE_CONFIG: begin
							if (cmd_value == sbst_pkg::CFG_NORMAL_CHANNEL_CONFIG) begin
								s_nxt.cfg_normal = 1'b1;
							end else if (cmd_value == sbst_pkg::CFG_AUTOMATIC_CHANNEL_CONFIG) begin
								s_nxt.cfg_normal = 1'b0;
							end else begin
								s_nxt.error = 1'b1;
							end
						end
						sbst_pkg::CMD_ROUTE_OPEN, sbst_pkg::CMD_ROUTE_CLOSE,
						sbst_pkg::CMD_ROUTE_RULE, sbst_pkg::CMD_ROUTE_SEQ,
						sbst_pkg::CMD_ROUTE_STATE: begin
							// Card number must suit the active config mode
							if (!((s_r.cfg_normal && card_in_range(cmd_arg)) ||
								(!s_r.cfg_normal && cmd_arg == sbst_pkg::CARD_AUTO) ||
								cmd_arg == sbst_pkg::CARD_ALL)) begin
								s_nxt.error = 1'b1;
							end else if ((cmd_code == sbst_pkg::CMD_ROUTE_RULE &&
								cmd_value > sbst_pkg::CONN_SINGLE_ROUTE_RULE) ||
								(cmd_code == sbst_pkg::CMD_ROUTE_SEQ &&
								cmd_value > sbst_pkg::SEQ_CLOSE_FIRST_SEQUENCE) ||
								(cmd_code == sbst_pkg::CMD_ROUTE_STATE &&
								cmd_value > sbst_pkg::BOOL_ON)) begin
								s_nxt.error = 1'b1;
							end else begin
								s_nxt.route_valid = 1'b1;
								s_nxt.route_card = cmd_arg;
								s_nxt.route_value = cmd_value;
								unique case (cmd_code)
									sbst_pkg::CMD_ROUTE_OPEN: s_nxt.route_op = sbst_pkg::ROP_OPEN;
									sbst_pkg::CMD_ROUTE_CLOSE: s_nxt.route_op = sbst_pkg::ROP_CLOSE;
									sbst_pkg::CMD_ROUTE_RULE: s_nxt.route_op = sbst_pkg::ROP_RULE;
									sbst_pkg::CMD_ROUTE_SEQ: s_nxt.route_op = sbst_pkg::ROP_SEQ;
									default: s_nxt.route_op = sbst_pkg::ROP_STATE;
								endcase
							end
						end
						default: begin
							s_nxt.error = 1'b1;
						end
					endcase
				end
			end
			ST_WAIT_OPS: begin
				if (!ops_pending) begin
					s_nxt.state = ST_IDLE;
				end
			end
			ST_HW_TEST: begin
				if (hw_test_done) begin
					if (s_r.test_kind == sbst_pkg::HW_CARD) begin
						s_nxt.wr_en = 1'b1;
						s_nxt.wr_idx = 3'(s_r.test_card - 3'h1);
						s_nxt.wr_fail = hw_test_fail;
						s_nxt.card_poweron[2'(s_r.test_card - 3'h1)] = 1'b1;
						s_nxt.acc_fail = s_r.acc_fail | hw_test_fail;
						if (s_r.test_card == s_r.last_card) begin
							s_nxt.test_req = 1'b0;
							s_nxt.rsp_valid = 1'b1;
							// Any failing card makes the whole reply a fail
							s_nxt.rsp_data = (s_r.acc_fail | hw_test_fail) ?
								sbst_pkg::RSP_FAIL : sbst_pkg::RSP_PASS;
							s_nxt.state = ST_IDLE;
						end else begin
							s_nxt.test_card = 3'(s_r.test_card + 3'h1);
						end
					end else begin
						s_nxt.test_req = 1'b0;
						s_nxt.rsp_valid = 1'b1;
						s_nxt.rsp_data = hw_test_fail ? sbst_pkg::RSP_FAIL : sbst_pkg::RSP_PASS;
						s_nxt.inst_reset = 1'b1;
						s_nxt.cfg_normal = 1'b1;
						if (s_r.test_kind == sbst_pkg::HW_CONTROLLER) begin
							s_nxt.wr_en = 1'b1;
							s_nxt.wr_idx = sbst_pkg::RES_IDX_CTRL;
							s_nxt.wr_fail = hw_test_fail;
						end
						s_nxt.state = ST_IDLE;
					end
				end
			end
			ST_PANEL: begin
				if (panel_done) begin
					// Panel test leaves every other setting as it was
					s_nxt.wr_en = 1'b1;
					s_nxt.wr_idx = sbst_pkg::RES_IDX_PANEL;
					s_nxt.wr_fail = panel_fail;
					s_nxt.rsp_valid = 1'b1;
					s_nxt.rsp_data = panel_fail ? sbst_pkg::RSP_FAIL : sbst_pkg::RSP_PASS;
					s_nxt.state = ST_IDLE;
				end
			end
		endcase
		s_nxt.ready = (s_nxt.state == ST_IDLE);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.state <= ST_IDLE;
			s_r.ready <= 1'b1;
			s_r.stb <= sbst_pkg::STB_RESET;
			s_r.opc <= 1'b1;
			s_r.cfg_normal <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Sub-blocks
	// ----------------------------------------------------------------
	sbst_result_store #(
		.ENTRIES(sbst_pkg::RES_ENTRIES)
	) u_store (
		.clk(clk),
		.rst_n(rst_n),
		.clr_mask(s_r.clr_mask),
		.wr_en(s_r.wr_en),
		.wr_idx(s_r.wr_idx),
		.wr_fail(s_r.wr_fail),
		.rd_idx(rd_idx),
		.rd_code(rd_code)
	);

	sbst_panel_watch #(
		.TIMEOUT_CYC(PANEL_TIMEOUT_CYC)
	) u_panel (
		.clk(clk),
		.rst_n(rst_n),
		.key_pin(panel_key),
		.start(s_r.panel_start),
		.done(panel_done),
		.fail(panel_fail)
	);

	assign cmd_ready = s_r.ready;
	assign cmd_error = s_r.error;
	assign rsp_valid = s_r.rsp_valid;
	assign rsp_data = s_r.rsp_data;
	assign summary_status_byte = s_r.stb;
	assign op_complete = s_r.opc;
	assign hw_test_req = s_r.test_req;
	assign hw_test_kind = s_r.test_kind;
	assign hw_test_card = s_r.test_card;
	assign inst_reset = s_r.inst_reset;
	assign card_poweron = s_r.card_poweron;
	assign route_valid = s_r.route_valid;
	assign route_op = s_r.route_op;
	assign route_card = s_r.route_card;
	assign route_value = s_r.route_value;
	assign channel_config = s_r.cfg_normal;

endmodule : sbst_handler

`default_nettype wire

// file: rtl/sbst_pkg.sv
// Shared constants and types of the status byte and self-test handler.
// Assumes a single 40 MHz clock domain and decoded commands from a parser.
`default_nettype none

package sbst_pkg;

	// ----------------------------------------------------------------
	// Status byte layout
	// ----------------------------------------------------------------
	localparam int STB_MAV_BIT = 4;
	localparam int STB_ESB_BIT = 5;
	localparam int STB_MSS_BIT = 6;
	localparam logic [7:0] STB_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Card and frame test selectors
	// ----------------------------------------------------------------
	localparam int CARD_COUNT = 4;
	localparam logic [2:0] CARD_AUTO = 3'h0;
	localparam logic [2:0] CARD_FIRST = 3'h1;
	localparam logic [2:0] CARD_LAST = 3'h4;
	localparam logic [2:0] CARD_ALL = 3'h7;
	localparam logic [2:0] FRAME_CTRL = 3'h0;
	localparam logic [2:0] FRAME_PANEL = 3'h1;
	localparam int RES_ENTRIES = 6;
	localparam logic [2:0] RES_IDX_CTRL = 3'h4;
	localparam logic [2:0] RES_IDX_PANEL = 3'h5;

	// Stored result codes and the reply bytes they map to
	localparam logic [1:0] RES_NONE = 2'h0;
	localparam logic [1:0] RES_PASS = 2'h1;
	localparam logic [1:0] RES_FAIL = 2'h2;
	localparam logic [7:0] RSP_PASS = 8'h00;
	localparam logic [7:0] RSP_FAIL = 8'h01;
	localparam logic [7:0] RSP_NONE = 8'hFF;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned PANEL_TIMEOUT_S = 10;
	localparam int unsigned PANEL_TIMEOUT_CYC = PANEL_TIMEOUT_S * CLK_HZ;

	// ----------------------------------------------------------------
	// Commands
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		CMD_STB_QUERY = 4'h0,
		CMD_SELFTEST_QUERY = 4'h1,
		CMD_WAIT = 4'h2,
		CMD_CARD_CLEAR = 4'h3,
		CMD_CARD_EXEC = 4'h4,
		CMD_CARD_STATE = 4'h5,
		CMD_FRAME_CLEAR = 4'h6,
		CMD_FRAME_EXEC = 4'h7,
		CMD_FRAME_STATE = 4'h8,
		CMD_ROUTE_OPEN = 4'h9,
		CMD_ROUTE_CLOSE = 4'hA,
		CMD_ROUTE_RULE = 4'hB,
		CMD_ROUTE_SEQ = 4'hC,
		CMD_ROUTE_CONFIG = 4'hD,
		CMD_ROUTE_STATE = 4'hE
	} sbst_cmd_t;

	typedef enum logic [2:0] {
		ROP_OPEN = 3'h0,
		ROP_CLOSE = 3'h1,
		ROP_RULE = 3'h2,
		ROP_SEQ = 3'h3,
		ROP_STATE = 3'h4
	} sbst_route_op_t;

	typedef enum logic [1:0] {
		HW_INTERNAL = 2'h0,
		HW_CONTROLLER = 2'h1,
		HW_CARD = 2'h2
	} sbst_hw_kind_t;

	// ----------------------------------------------------------------
	// Routing parameter encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CONN_FREE = 2'h0,
		CONN_SINGLE_ROUTE_RULE = 2'h1
	} sbst_conn_rule_t;

	typedef enum logic [1:0] {
		SEQ_NO_ORDER_SEQUENCE = 2'h0,
		SEQ_OPEN_FIRST_SEQUENCE = 2'h1,
		SEQ_CLOSE_FIRST_SEQUENCE = 2'h2
	} sbst_sequence_t;

	typedef enum logic [1:0] {
		CFG_AUTOMATIC_CHANNEL_CONFIG = 2'h0,
		CFG_NORMAL_CHANNEL_CONFIG = 2'h1
	} sbst_chan_cfg_t;

	// Boolean state: OFF and 0 map to 0, ON and 1 map to 1
	localparam logic [1:0] BOOL_OFF = 2'h0;
	localparam logic [1:0] BOOL_ON = 2'h1;

endpackage : sbst_pkg

`default_nettype wire

// file: rtl/sbst_result_store.sv
// Stored pass/fail results of the four cards and the two frame tests.
// Assumes writer and clearer share the clock; read port is combinational.
`default_nettype none

module sbst_result_store #(
	parameter int ENTRIES = sbst_pkg::RES_ENTRIES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ENTRIES-1:0] clr_mask,
	input wire logic wr_en,
	input wire logic [2:0] wr_idx,
	input wire logic wr_fail,
	input wire logic [2:0] rd_idx,
	output logic [1:0] rd_code
);

	typedef struct packed {
		logic [ENTRIES-1:0][1:0] res;
	} sbst_store_t;

	sbst_store_t s_r;
	sbst_store_t s_nxt;
	logic [ENTRIES-1:0][1:0] res_nxt;

	// ----------------------------------------------------------------
	// Per-entry update
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < ENTRIES; gi++) begin : g_entry
			always_comb begin
				res_nxt[gi] = s_r.res[gi];
				if (clr_mask[gi]) begin
					res_nxt[gi] = sbst_pkg::RES_NONE;
				end
				// A new result outranks a clear in the same cycle
				if (wr_en && (wr_idx == 3'(gi))) begin
					res_nxt[gi] = wr_fail ? sbst_pkg::RES_FAIL : sbst_pkg::RES_PASS;
				end
			end
		end
	endgenerate

	always_comb begin
		s_nxt.res = res_nxt;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rd_code = (int'(rd_idx) < ENTRIES) ? s_r.res[rd_idx] : sbst_pkg::RES_NONE;

endmodule : sbst_result_store

`default_nettype wire

// file: rtl/sbst_panel_watch.sv
// Front panel key watcher with a timeout for the panel interface test.
// Assumes key_pin is asynchronous to clk and active high while pressed.
`default_nettype none

module sbst_panel_watch #(
	parameter int unsigned TIMEOUT_CYC = sbst_pkg::PANEL_TIMEOUT_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic key_pin,
	input wire logic start,
	output logic done,
	output logic fail
);

	localparam int CW = $clog2(TIMEOUT_CYC + 1);

	typedef struct packed {
		logic key_meta;
		logic key_sync;
		logic busy;
		logic [CW-1:0] count;
		logic done;
		logic fail;
	} sbst_watch_t;

	sbst_watch_t s_r;
	sbst_watch_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.key_meta = key_pin;
		s_nxt.key_sync = s_r.key_meta;
		s_nxt.done = 1'b0;
		if (start) begin
			s_nxt.busy = 1'b1;
			s_nxt.count = '0;
		end else if (s_r.busy) begin
			if (s_r.key_sync) begin
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
				s_nxt.fail = 1'b0;
			end else if (s_r.count == CW'(TIMEOUT_CYC - 1)) begin
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
				s_nxt.fail = 1'b1;
			end else begin
				s_nxt.count = CW'(s_r.count + 1'b1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign done = s_r.done;
	assign fail = s_r.fail;

endmodule : sbst_panel_watch

`default_nettype wire

// file: verification/sbst_handler_assertions.sv
// Port-level assertions on the status byte and self-test handler.
// Bound from the bench top; one clock domain, synchronous reset.
`default_nettype none
module sbst_handler_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire logic [3:0] cmd_code,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic [7:0] event_status,
	input wire logic [7:0] event_enable,
	input wire logic [7:0] request_enable,
	input wire logic ops_pending,
	input wire logic [7:0] summary_status_byte,
	input wire logic op_complete,
	input wire logic [2:0] hw_test_card,
	input wire logic hw_test_done,
	input wire logic inst_reset,
	input wire logic [3:0] card_poweron,
	input wire logic channel_config
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire tk = cmd_valid && cmd_ready;

	a_stb_unused: assert property (summary_status_byte[3:0] == 4'h0 && !summary_status_byte[7])
		else $error("unused status bits set");
	a_stb_esb: assert property ($past(rst_n) |->
		summary_status_byte[5] == |($past(event_status) & $past(event_enable)))
		else $error("event summary bit wrong");
	a_stb_mss: assert property ($past(rst_n) |->
		summary_status_byte[6] == |(summary_status_byte[5:4] & $past(request_enable[5:4])))
		else $error("master summary bit wrong");
	a_opc_track: assert property ($past(rst_n) |-> op_complete == !$past(ops_pending))
		else $error("operation complete wrong");
	a_stb_reply: assert property (tk && cmd_code == 4'h0 |=>
		rsp_valid && rsp_data == summary_status_byte)
		else $error("status reply wrong");
	a_wait_hold: assert property (tk && cmd_code == 4'h2 && ops_pending |=> !cmd_ready)
		else $error("wait did not stall");
	a_reset_reply: assert property (inst_reset |-> rsp_valid && channel_config)
		else $error("reset state missing");
	a_poweron_card: assert property (card_poweron != 4'h0 |-> $past(hw_test_done) &&
		card_poweron == (4'h1 << ($past(hw_test_card) - 3'h1)))
		else $error("power-on restore wrong");
endmodule : sbst_handler_chk
`default_nettype wire

// file: verification/sbst_test_engine.sv
// Model of the test hardware answering the handler's test requests.
// Same clock as the handler; done is a one-cycle pulse.
`default_nettype none
module sbst_test_engine (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req,
	input wire logic [1:0] kind,
	input wire logic [2:0] card,
	input wire logic [2:0] bad_card,
	input wire logic [7:0] dly,
	output logic done,
	output logic fail
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt;
	always @(posedge clk) begin
		if (!rst_n || !req || done) begin
			done <= 1'b0;
			cnt <= 8'h00;
			// Fail is only meaningful with done, so it does not hold its value
			fail <= rst_n ? ~fail : 1'b0;
		end else if (cnt == dly) begin
			done <= 1'b1;
			fail <= kind == sbst_pkg::HW_CARD && card == bad_card;
			cnt <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule : sbst_test_engine
`default_nettype wire

// file: verification/test_sbst_handler.sv
// Self-checking bench of the status byte and self-test handler.
// Drives decoded commands; a test engine model answers test requests.
`default_nettype none
module test_sbst_handler;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, cmd_valid, out_queue_empty, ops_pending, panel_key;
	logic cmd_ready, cmd_error, rsp_valid, op_complete, hw_test_req, hw_test_done;
	logic hw_test_fail, inst_reset, route_valid, channel_config;
	logic [3:0] cmd_code, card_poweron;
	logic [2:0] cmd_arg, hw_test_card, route_op, route_card, bad_card;
	logic [1:0] cmd_value, hw_test_kind, route_value;
	logic [7:0] rsp_data, event_status, event_enable, request_enable;
	logic [7:0] summary_status_byte, dly;
	int mismatches, cmp_count;
	logic [32:0] rows [7] = '{{24'h000000, 1'b1, 8'h00}, {24'h000000, 1'b0, 8'h10},
		{24'h000010, 1'b0, 8'h50}, {24'h202000, 1'b1, 8'h20}, {24'h202020, 1'b0, 8'h70},
		{24'h210130, 1'b1, 8'h60}, {24'h807FFF, 1'b1, 8'h00}};

	sbst_handler #(.PANEL_TIMEOUT_CYC(50)) dut_u (.*);
	sbst_test_engine eng_u (.clk, .rst_n, .req(hw_test_req), .kind(hw_test_kind),
		.card(hw_test_card), .bad_card, .dly, .done(hw_test_done), .fail(hw_test_fail));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic summarize();
		if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic cmd(input logic [3:0] c, input logic [2:0] a, input logic [1:0] v);
		@(negedge clk);
		while (cmd_ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_arg <= a;
		cmd_value <= v;
		@(posedge clk);
		cmd_valid <= 1'b0;
	endtask : cmd
	// Refusals come back as EE and silence as DD, so one compare covers all three
	task automatic q(input logic [3:0] c, input logic [2:0] a, input logic [7:0] exp);
		int n;
		cmd(c, a, 2'h0);
		n = 0;
		while (rsp_valid !== 1'b1 && cmd_error !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		chk((cmd_error === 1'b1) ? 8'hEE : (rsp_valid === 1'b1) ? rsp_data : 8'hDD, exp);
	endtask : q
	// Route outputs packed as op, card and value; EE refused, DD nothing issued
	task automatic rt(input logic [3:0] c, input logic [2:0] a, input logic [1:0] v,
		input logic [7:0] exp);
		cmd(c, a, v);
		@(negedge clk);
		chk((route_valid === 1'b1) ? {route_op, route_card, route_value} :
			(cmd_error === 1'b1) ? 8'hEE : 8'hDD, exp);
	endtask : rt

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		summarize();
	end
	initial begin
		{rst_n, cmd_valid, ops_pending, panel_key, cmd_code, cmd_arg, cmd_value} = '0;
		{event_status, event_enable, request_enable} = '0;
		out_queue_empty = 1'b1;
		bad_card = 3'h3;
		dly = 8'h02;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk(summary_status_byte, 8'h00);
		chk({6'h00, op_complete, channel_config}, 8'h03);
		for (int i = 0; i < 7; i++) begin
			@(posedge clk);
			{event_status, event_enable, request_enable, out_queue_empty} <= rows[i][32:8];
			q(4'h0, 3'h0, rows[i][7:0]);
		end
		for (int c = 1; c < 7; c++) q(c < 5 ? 4'h5 : 4'h8, 3'(c < 5 ? c : c - 5), 8'hFF);
		q(4'h4, 3'h7, 8'h01);
		q(4'h5, 3'h3, 8'h01);
		q(4'h5, 3'h1, 8'h00);
		cmd(4'h3, 3'h3, 2'h0);
		q(4'h5, 3'h3, 8'hFF);
		dly = 8'h14;
		q(4'h4, 3'h2, 8'h00);
		q(4'h5, 3'h7, 8'hEE);
		q(4'h4, 3'h5, 8'hEE);
		cmd(4'hD, 3'h0, 2'h0);
		@(negedge clk);
		chk({7'h00, channel_config}, 8'h00);
		q(4'h1, 3'h0, 8'h00);
		chk({6'h00, inst_reset, channel_config}, 8'h03);
		rt(4'h9, 3'h2, 2'h0, 8'h08);
		rt(4'hA, 3'h7, 2'h0, 8'h3C);
		rt(4'hB, 3'h1, 2'h2, 8'hEE);
		rt(4'hC, 3'h4, 2'h2, 8'h72);
		rt(4'hE, 3'h0, 2'h1, 8'hEE);
		rt(4'hD, 3'h0, 2'h3, 8'hEE);
		rt(4'hD, 3'h0, 2'h0, 8'hDD);
		rt(4'hE, 3'h0, 2'h1, 8'h81);
		rt(4'h9, 3'h1, 2'h0, 8'hEE);
		rt(4'hE, 3'h0, 2'h2, 8'hEE);
		q(4'h7, 3'h0, 8'h00);
		chk({6'h00, inst_reset, channel_config}, 8'h03);
		q(4'h8, 3'h0, 8'h00);
		fork
			q(4'h7, 3'h1, 8'h00);
			begin
				repeat (6) @(posedge clk);
				panel_key <= 1'b1;
			end
		join
		chk({6'h00, inst_reset, channel_config}, 8'h01);
		@(posedge clk);
		panel_key <= 1'b0;
		q(4'h7, 3'h1, 8'h01);
		q(4'h8, 3'h1, 8'h01);
		cmd(4'h6, 3'h1, 2'h0);
		q(4'h8, 3'h1, 8'hFF);
		q(4'h8, 3'h0, 8'h00);
		@(posedge clk);
		ops_pending <= 1'b1;
		cmd(4'h2, 3'h0, 2'h0);
		repeat (5) @(negedge clk);
		chk({6'h00, cmd_ready, op_complete}, 8'h00);
		@(posedge clk);
		ops_pending <= 1'b0;
		q(4'h0, 3'h0, 8'h00);
		summarize();
	end
endmodule : test_sbst_handler

bind sbst_handler sbst_handler_chk chk_u (.*);
`default_nettype wire
